// ### inc/ufi_pkg.sv
// Function
// - Ready-pin mode chosen by DMA select bit while FIFOs enabled, else mode 0
// - Mode 0: tx ready low while nothing queued
// - Mode 0: rx ready low while data held
// - Mode 1: tx ready high only when full
// - Mode 1: rx ready on trigger/timeout, until empty
// - Transmit-empty interrupt when count below trigger
// - Tx trigger code 00 is 1, 11 is 14
// - Rx interrupt at trigger; FIFO keeps filling
// - Rx trigger 01=4, 10=8, 11=14, reset 8
// - Seven prioritised levels, highest reported first
// - Source read clears only the reported interrupt
// - Fixed six-bit codes per interrupt source
// - Bit 0 low while pending, high idle
// - Bits 4,5 need enhanced bit; Xoff until Xon
// - Bits 7:6 mirror FIFO enable
// - Word length 5 to 8 bits
// - Stop bits: 1, 1.5 or 2
// - Parity enable bit adds and checks parity
// - Parity odd or even select
// - Forced parity: 1 or 0
// - Break bit holds transmit line low
// - Rx data interrupt clears below trigger
`default_nettype none
package ufi_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFS_ISR_FSETUP = 8'h08;
  localparam logic [7:0] OFS_LINE_FMT   = 8'h0C;
  localparam logic [7:0] OFS_ENH_CTL    = 8'h10;
  localparam logic [7:0] OFS_FSETUP_RB  = 8'h14;
  localparam logic [7:0] FSETUP_RST     = 8'h00;
  localparam logic [7:0] LINE_FMT_RST   = 8'h00;
  localparam logic [7:0] ENH_CTL_RST    = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned FS_EN     = 0;
  localparam int unsigned FS_RXCLR  = 1;
  localparam int unsigned FS_TXCLR  = 2;
  localparam int unsigned FS_DMA    = 3;
  localparam int unsigned FS_TXTRG  = 4;
  localparam int unsigned FS_RXTRG  = 6;
  localparam int unsigned LF_WLEN   = 0;
  localparam int unsigned LF_STOP   = 2;
  localparam int unsigned LF_PEN    = 3;
  localparam int unsigned LF_EVEN   = 4;
  localparam int unsigned LF_FORCE  = 5;
  localparam int unsigned LF_BRK    = 6;
  localparam int unsigned EFR_ENH   = 4;
  // ****************************************
  // Levels, masks and codes
  // ****************************************
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;
  localparam logic [CNT_W-1:0] TRG_1  = 5'h01;
  localparam logic [CNT_W-1:0] TRG_4  = 5'h04;
  localparam logic [CNT_W-1:0] TRG_8  = 5'h08;
  localparam logic [CNT_W-1:0] TRG_14 = 5'h0E;
  localparam logic [7:0] WL_MASK5 = 8'h1F;
  localparam logic [7:0] WL_MASK6 = 8'h3F;
  localparam logic [7:0] WL_MASK7 = 8'h7F;
  localparam logic [7:0] WL_MASK8 = 8'hFF;
  localparam logic [5:0] ISR_NONE  = 6'h01;
  localparam logic [5:0] ISR_LINE  = 6'h06;
  localparam logic [5:0] ISR_RXD   = 6'h04;
  localparam logic [5:0] ISR_RTO   = 6'h0C;
  localparam logic [5:0] ISR_TXE   = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XOFF  = 6'h10;
  localparam logic [5:0] ISR_FLOW  = 6'h20;
  localparam logic [2:0] RTO_CHARS = 3'h4;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SRC_NONE, SRC_LINE, SRC_RXD, SRC_RTO,
    SRC_TXE, SRC_MODEM, SRC_XOFF, SRC_FLOW
  } ufi_src_type;
  typedef struct packed {
    logic [CNT_W-1:0] tx_count;
    logic [CNT_W-1:0] rx_count;
    logic             rx_push;
    logic             rx_pop;
    logic             char_tick;
  } ufi_fifo_type;
  typedef struct packed {
    logic lsr_int;
    logic modem_int;
    logic xoff_hit;
    logic xon_hit;
    logic flow_chg;
  } ufi_evt_type;
  typedef struct packed {
    logic [1:0] wlen;
    logic       stop_long;
    logic       stop_half;
    logic       par_en;
    logic       par_even;
    logic       par_force;
    logic       par_force_val;
  } ufi_cfg_type;
endpackage
`default_nettype wire

// ### core/ufi_top.sv
`timescale 1ns/1ps
`default_nettype none
module ufi_top
(
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ufi_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // FIFO state and events from the datapath
  input  wire ufi_pkg::ufi_fifo_type       fifo_st,
  input  wire ufi_pkg::ufi_evt_type        evt,
  // Character paths
  input  wire logic [7:0]                  tx_char,
  input  wire logic [7:0]                  rx_char,
  input  wire logic                        rx_par_bit,
  input  wire logic                        rx_par_stb,
  input  wire logic                        tx_serial,
  // Pins and control outputs
  output logic                             tx_ready_n,
  output logic                             rx_ready_n,
  output logic                             tx_line,
  output logic                             tx_par_bit,
  output logic                             rx_par_err,
  output ufi_pkg::ufi_cfg_type             line_cfg,
  output logic                             fifo_en,
  output logic                             rx_fifo_clr,
  output logic                             tx_fifo_clr,
  output logic                             int_pending
);
  import ufi_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] tx_level(input logic [1:0] code);
    case (code)
      2'h0:    tx_level = TRG_1;
      2'h1:    tx_level = TRG_4;
      2'h2:    tx_level = TRG_8;
      default: tx_level = TRG_14;
    endcase
  endfunction

  // Cleared field gives 8, so 00 and 10 share a level
  function automatic logic [CNT_W-1:0] rx_level(input logic [1:0] code);
    case (code)
      2'h1:    rx_level = TRG_4;
      2'h3:    rx_level = TRG_14;
      default: rx_level = TRG_8;
    endcase
  endfunction

  function automatic logic par_calc(input logic [7:0] data,
                                    input logic [7:0] fmt);
    logic [7:0] m;
    m = WL_MASK8;
    case (fmt[LF_WLEN +: 2])
      2'h0:    m = WL_MASK5;
      2'h1:    m = WL_MASK6;
      2'h2:    m = WL_MASK7;
      default: m = WL_MASK8;
    endcase
    if (fmt[LF_FORCE])
      par_calc = ~fmt[LF_EVEN];
    else
      par_calc = (^(data & m)) ^ ~fmt[LF_EVEN];
  endfunction

  function automatic logic [5:0] src_code(input ufi_src_type s);
    case (s)
      SRC_LINE:  src_code = ISR_LINE;
      SRC_RXD:   src_code = ISR_RXD;
      SRC_RTO:   src_code = ISR_RTO;
      SRC_TXE:   src_code = ISR_TXE;
      SRC_MODEM: src_code = ISR_MODEM;
      SRC_XOFF:  src_code = ISR_XOFF;
      SRC_FLOW:  src_code = ISR_FLOW;
      default:   src_code = ISR_NONE;
    endcase
  endfunction

  function automatic logic mapped(input logic [APB_AW-1:0] a);
    mapped = (a == OFS_ISR_FSETUP) || (a == OFS_LINE_FMT) ||
             (a == OFS_ENH_CTL) || (a == OFS_FSETUP_RB);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]       fsetup_q;
  logic [7:0]       line_fmt_q;
  logic [7:0]       enh_q;
  logic             dma1;
  logic             enh;
  logic [CNT_W-1:0] tx_trig;
  logic [CNT_W-1:0] rx_trig;
  logic             apb_setup;
  logic             apb_access;
  logic             isr_rd;
  logic             fs_wr;
  ufi_src_type      rep_q;
  ufi_src_type      cur_src;
  logic [7:0]       isr_byte;
  logic             rxd_lvl;
  logic             tx_below;
  logic             below_q;
  logic             txe_q;
  logic             txe_set;
  logic             rto_q;
  logic             rto_set;
  logic [2:0]       rto_cnt_q;
  logic             rx_has;
  logic             xoff_q;
  logic             flow_q;
  logic             flow_set;

  assign dma1    = fsetup_q[FS_EN] & fsetup_q[FS_DMA];
  assign enh     = enh_q[EFR_ENH];
  assign tx_trig = tx_level(fsetup_q[FS_TXTRG +: 2]);
  assign rx_trig = rx_level(fsetup_q[FS_RXTRG +: 2]);
  assign rx_has  = fifo_st.rx_count != '0;

  // ****************************************
  // APB slave: one wait-free access cycle
  // ****************************************
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable & pready;
  assign isr_rd     = apb_access & ~pwrite & (paddr == OFS_ISR_FSETUP);
  assign fs_wr      = apb_access & pwrite & (paddr == OFS_ISR_FSETUP);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready <= apb_setup;
      if (apb_setup)
      begin
        pslverr <= ~mapped(paddr);
        case (paddr)
          OFS_ISR_FSETUP: prdata <= {24'h000000, isr_byte};
          OFS_LINE_FMT:   prdata <= {24'h000000, line_fmt_q};
          OFS_ENH_CTL:    prdata <= {24'h000000, enh_q};
          OFS_FSETUP_RB:  prdata <= {24'h000000, fsetup_q};
          default:        prdata <= '0;
        endcase
      end
    end
  end

  // Source is frozen at setup so the read clears what it returned
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rep_q <= SRC_NONE;
    else if (apb_setup)
      rep_q <= cur_src;
  end

  // ****************************************
  // Registers written by software
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fsetup_q <= FSETUP_RST;
    else if (fs_wr)
    begin
      // Without the enable bit only the enable itself changes
      if (pwdata[FS_EN])
        fsetup_q <= {pwdata[7:3], 2'b00, 1'b1};
      else
        fsetup_q[FS_EN] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_fifo_clr <= 1'b0;
      tx_fifo_clr <= 1'b0;
    end
    else
    begin
      rx_fifo_clr <= fs_wr & pwdata[FS_EN] & pwdata[FS_RXCLR];
      tx_fifo_clr <= fs_wr & pwdata[FS_EN] & pwdata[FS_TXCLR];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      line_fmt_q <= LINE_FMT_RST;
    else if (apb_access & pwrite & (paddr == OFS_LINE_FMT))
      line_fmt_q <= pwdata[7:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      enh_q <= ENH_CTL_RST;
    else if (apb_access & pwrite & (paddr == OFS_ENH_CTL))
      enh_q <= pwdata[7:0];
  end

  // ****************************************
  // Interrupt sources
  // ****************************************
  // Without FIFOs a single held character meets the level
  assign rxd_lvl  = fsetup_q[FS_EN] ?
                    (fifo_st.rx_count >= rx_trig) : rx_has;
  assign tx_below = fsetup_q[FS_EN] ?
                    (fifo_st.tx_count < tx_trig)
                    : (fifo_st.tx_count == '0);
  assign txe_set  = tx_below & ~below_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      below_q <= 1'b0;
      txe_q   <= 1'b0;
    end
    else
    begin
      below_q <= tx_below;
      // New event beats a clearing read in the same cycle
      if (txe_set)
        txe_q <= 1'b1;
      else if (~tx_below | (isr_rd & (rep_q == SRC_TXE)))
        txe_q <= 1'b0;
    end
  end

  // Any arrival or read restarts the idle count
  assign rto_set = fsetup_q[FS_EN] & rx_has & fifo_st.char_tick &
                   ~fifo_st.rx_push & ~fifo_st.rx_pop &
                   (rto_cnt_q == RTO_CHARS - 3'h1);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rto_cnt_q <= '0;
      rto_q     <= 1'b0;
    end
    else
    begin
      if (~rx_has | fifo_st.rx_push | fifo_st.rx_pop)
        rto_cnt_q <= '0;
      else if (fifo_st.char_tick & (rto_cnt_q != RTO_CHARS))
        rto_cnt_q <= rto_cnt_q + 3'h1;
      if (rto_set)
        rto_q <= 1'b1;
      else if (~rx_has | fifo_st.rx_pop |
               (isr_rd & (rep_q == SRC_RTO)))
        rto_q <= 1'b0;
    end
  end

  assign flow_set = enh & evt.flow_chg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xoff_q <= 1'b0;
      flow_q <= 1'b0;
    end
    else
    begin
      // Xoff is not cleared by reading, only by Xon
      if (enh & evt.xoff_hit)
        xoff_q <= 1'b1;
      else if (evt.xon_hit)
        xoff_q <= 1'b0;
      if (flow_set)
        flow_q <= 1'b1;
      else if (isr_rd & (rep_q == SRC_FLOW))
        flow_q <= 1'b0;
    end
  end

  // ****************************************
  // Priority and source byte
  // ****************************************
  always_comb
  begin
    if (evt.lsr_int)
      cur_src = SRC_LINE;
    else if (rxd_lvl)
      cur_src = SRC_RXD;
    else if (rto_q)
      cur_src = SRC_RTO;
    else if (txe_q)
      cur_src = SRC_TXE;
    else if (evt.modem_int)
      cur_src = SRC_MODEM;
    else if (enh & xoff_q)
      cur_src = SRC_XOFF;
    else if (enh & flow_q)
      cur_src = SRC_FLOW;
    else
      cur_src = SRC_NONE;
  end

  assign isr_byte = {{2{fsetup_q[FS_EN]}}, src_code(cur_src)};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      int_pending <= 1'b0;
    else
      int_pending <= (cur_src != SRC_NONE);
  end

  // ****************************************
  // Ready pins
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tx_ready_n <= 1'b0;
    else if (dma1)
      tx_ready_n <= (fifo_st.tx_count == FIFO_DEPTH);
    else
      tx_ready_n <= (fifo_st.tx_count != '0);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rx_ready_n <= 1'b1;
    else if (!dma1)
      rx_ready_n <= ~rx_has;
    else if (!rx_has)
      rx_ready_n <= 1'b1;
    else if ((fifo_st.rx_count >= rx_trig) | rto_q)
      rx_ready_n <= 1'b0;
  end

  // ****************************************
  // Line format and serial path
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_cfg <= '0;
      fifo_en  <= 1'b0;
    end
    else
    begin
      fifo_en                <= fsetup_q[FS_EN];
      line_cfg.wlen          <= line_fmt_q[LF_WLEN +: 2];
      line_cfg.stop_long     <= line_fmt_q[LF_STOP];
      // Half stop only exists for five-bit words
      line_cfg.stop_half     <= line_fmt_q[LF_STOP] &
                                (line_fmt_q[LF_WLEN +: 2] == 2'h0);
      line_cfg.par_en        <= line_fmt_q[LF_PEN];
      line_cfg.par_even      <= line_fmt_q[LF_EVEN];
      line_cfg.par_force     <= line_fmt_q[LF_FORCE];
      line_cfg.par_force_val <= ~line_fmt_q[LF_EVEN];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_line    <= 1'b1;
      tx_par_bit <= 1'b0;
      rx_par_err <= 1'b0;
    end
    else
    begin
      tx_line    <= tx_serial & ~line_fmt_q[LF_BRK];
      tx_par_bit <= par_calc(tx_char, line_fmt_q);
      if (rx_par_stb)
        rx_par_err <= line_fmt_q[LF_PEN] &
                      (rx_par_bit != par_calc(rx_char, line_fmt_q));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_tx_ready_n_mode_zero: assert property (
    (!dma1 && fifo_st.tx_count == '0) |=> !tx_ready_n)
    else $error("tx ready not low with nothing queued");
  a_tx_ready_n_full: assert property (
    dma1 |=> tx_ready_n == ($past(fifo_st.tx_count) == FIFO_DEPTH))
    else $error("tx ready wrong in block mode");
  a_rx_ready_n_mode_zero: assert property (
    (!dma1 && rx_has) |=> !rx_ready_n)
    else $error("rx ready not low with data held");
  a_rx_ready_n_empty: assert property (
    (dma1 && !rx_has) |=> rx_ready_n)
    else $error("rx ready not released on empty");
  a_isr_idle_bits: assert property (
    (apb_setup && paddr == OFS_ISR_FSETUP && cur_src == SRC_NONE)
    |=> prdata[0] && prdata[7:6] == {2{$past(fsetup_q[FS_EN])}})
    else $error("idle source byte wrong");
  a_isr_line_first: assert property (
    (apb_setup && paddr == OFS_ISR_FSETUP && evt.lsr_int)
    |=> prdata[5:0] == ISR_LINE)
    else $error("line status not reported first");
  a_txe_read_clear: assert property (
    (isr_rd && rep_q == SRC_TXE && !txe_set) |=> !txe_q)
    else $error("reported tx empty not cleared");
  a_rto_raise: assert property (
    rto_set |=> rto_q ##1 (rto_q || !$past(rx_has) || $past(fifo_st.rx_pop)
                           || $past(isr_rd)))
    else $error("rx timeout not raised");
  a_break_low: assert property (
    line_fmt_q[LF_BRK] |=> !tx_line)
    else $error("break not holding line low");
  a_fsetup_hold: assert property (
    (fs_wr && !pwdata[FS_EN]) |=> fsetup_q[7:1] == $past(fsetup_q[7:1]))
    else $error("setup bits changed without enable");
  a_par_forced: assert property (
    (line_fmt_q[LF_FORCE] && !line_fmt_q[LF_EVEN]) |=> tx_par_bit)
    else $error("forced parity one not applied");
endmodule // ufi_top
`default_nettype wire

// ### sim/ufi_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufi_line_model
  import ufi_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Bench commands: add, take, tick
  input  wire logic [2:0]            cmd,
  input  wire logic [4:0]            tx_lvl,
  input  wire logic                  rx_clr,
  // State seen by the block
  output var  ufi_pkg::ufi_fifo_type fifo_st
);
  logic [4:0] rx_q;

  // Full FIFO drops the character, as an overrun would
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rx_q <= 5'h00;
    else if (rx_clr)
      rx_q <= 5'h00;
    else if (cmd[2] && rx_q != FIFO_DEPTH)
      rx_q <= rx_q + 5'h01;
    else if (cmd[1] && rx_q != 5'h00)
      rx_q <= rx_q - 5'h01;

  assign fifo_st = {tx_lvl, rx_q, cmd};
endmodule // ufi_line_model
`default_nettype wire

// ### sim/uart_fifo_format_interrupt_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_format_interrupt_tb;
  import ufi_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, tx_char, f;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr, tx_line, tx_par_bit, tx_serial, tx_ready_n, rx_ready_n;
  logic rx_fifo_clr, p, e_par, rx_par_bit, rx_par_stb, rx_par_err;
  logic fifo_en, tx_fifo_clr, int_pending;
  logic [2:0] cmd;
  logic [4:0] tx_lvl, ev;
  ufi_fifo_type fifo_st;
  ufi_cfg_type line_cfg;
  int n_errors, checks, cyc;
  logic [4:0] rl [4] = '{TRG_8, TRG_4, TRG_8, TRG_14};
  logic [4:0] tl [4] = '{TRG_1, TRG_4, TRG_8, TRG_14};
  logic [7:0] lft [6] = '{8'h08, 8'h1D, 8'h2C, 8'h3B, 8'h0E, 8'h00};

  ufi_top DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_st(fifo_st), .evt(ev),
    .tx_char(tx_char), .rx_char(tx_char), .rx_par_bit(rx_par_bit),
    .rx_par_stb(rx_par_stb), .tx_serial(tx_serial),
    .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n), .tx_line(tx_line),
    .tx_par_bit(tx_par_bit), .rx_par_err(rx_par_err), .line_cfg(line_cfg),
    .fifo_en(fifo_en), .rx_fifo_clr(rx_fifo_clr),
    .tx_fifo_clr(tx_fifo_clr), .int_pending(int_pending));
  ufi_line_model line_model (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
    .tx_lvl(tx_lvl), .rx_clr(rx_fifo_clr), .fifo_st(fifo_st));

  always #25 mclk = ~mclk;

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("prdata", {24'h000000, e}, rdat);
  endtask
  // Held command counts one event per cycle
  task automatic go(input int n, input logic [2:0] v);
    cmd <= v;
    repeat (n) @(posedge mclk);
    cmd <= 3'h0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic lvl(input logic [4:0] v);
    tx_lvl <= v;
    repeat (3) @(posedge mclk);
  endtask
  task automatic evs(input logic [4:0] v, input logic hold);
    ev <= v;
    @(posedge mclk);
    if (!hold)
      ev <= 5'h00;
    repeat (2) @(posedge mclk);
  endtask
  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      close_out;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {mclk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {cmd, tx_lvl, ev, n_errors, checks, cyc} = '0;
    tx_char = 8'hE1;
    tx_serial = 1'b1;
    {rx_par_bit, rx_par_stb} = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("tx_ready_n", 0, tx_ready_n);
    chk("rx_ready_n", 1, rx_ready_n);
    rd(OFS_LINE_FMT, LINE_FMT_RST);
    rd(OFS_FSETUP_RB, FSETUP_RST);
    rd(OFS_ENH_CTL, ENH_CTL_RST);
    rd(OFS_ISR_FSETUP, 8'h02);
    rd(OFS_ISR_FSETUP, 8'h01);
    apb(1'b0, 8'h20, 8'h00);
    chk("pslverr", 1, rerr);
    chk("prdata", 0, rdat);
    chk("int_pending", 0, int_pending);
    lvl(5'h01);
    chk("tx_ready_n", 1, tx_ready_n);
    go(1, 3'b100);
    chk("rx_ready_n", 0, rx_ready_n);
    rd(OFS_ISR_FSETUP, 8'h04);
    go(1, 3'b010);
    chk("rx_ready_n", 1, rx_ready_n);
    rd(OFS_ISR_FSETUP, 8'h01);
    lvl(FIFO_DEPTH);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, OFS_ISR_FSETUP, {c[1:0], c[1:0], 4'h3});
      go(rl[c] - 1, 3'b100);
      chk("rx_ready_n", 0, rx_ready_n);
      rd(OFS_ISR_FSETUP, 8'hC1);
      go(1, 3'b100);
      rd(OFS_ISR_FSETUP, 8'hC4);
      go(1, 3'b010);
      rd(OFS_ISR_FSETUP, 8'hC1);
      lvl(tl[c]);
      lvl(tl[c] - 5'h01);
      rd(OFS_ISR_FSETUP, 8'hC2);
      rd(OFS_ISR_FSETUP, 8'hC1);
      lvl(FIFO_DEPTH);
    end
    apb(1'b1, OFS_ISR_FSETUP, 8'h0F);
    chk("tx_fifo_clr", 1, tx_fifo_clr);
    rd(OFS_FSETUP_RB, 8'h09);
    chk("fifo_en", 1, fifo_en);
    lvl(5'h0F);
    chk("tx_ready_n", 0, tx_ready_n);
    lvl(FIFO_DEPTH);
    chk("tx_ready_n", 1, tx_ready_n);
    go(1, 3'b100);
    chk("rx_ready_n", 1, rx_ready_n);
    go(4, 3'b001);
    chk("rx_ready_n", 0, rx_ready_n);
    rd(OFS_ISR_FSETUP, 8'hCC);
    go(1, 3'b010);
    chk("rx_ready_n", 1, rx_ready_n);
    // ****************************************
    // Interrupt priority and flow events
    // ****************************************
    apb(1'b1, OFS_ENH_CTL, 8'h10);
    evs(5'h18, 1'b1);
    chk("int_pending", 1, int_pending);
    rd(OFS_ISR_FSETUP, 8'hC6);
    evs(5'h08, 1'b1);
    rd(OFS_ISR_FSETUP, 8'hC0);
    evs(5'h00, 1'b1);
    evs(5'h04, 1'b0);
    rd(OFS_ISR_FSETUP, 8'hD0);
    rd(OFS_ISR_FSETUP, 8'hD0);
    evs(5'h02, 1'b0);
    evs(5'h01, 1'b0);
    rd(OFS_ISR_FSETUP, 8'hE0);
    rd(OFS_ISR_FSETUP, 8'hC1);
    apb(1'b1, OFS_ENH_CTL, 8'h00);
    evs(5'h01, 1'b0);
    rd(OFS_ISR_FSETUP, 8'hC1);
    apb(1'b1, OFS_ISR_FSETUP, 8'hF8);
    rd(OFS_FSETUP_RB, 8'h08);
    chk("fifo_en", 0, fifo_en);
    rd(OFS_ISR_FSETUP, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      f = lft[i];
      apb(1'b1, OFS_LINE_FMT, f);
      rd(OFS_LINE_FMT, f);
      p = ^(tx_char & (8'hFF >> (2'h3 - f[1:0])));
      chk("line_cfg", {f[1:0], f[2],
          f[2] & (f[1:0] == 2'h0), f[3], f[4], f[5], ~f[4]}, line_cfg);
      e_par = f[5] ? ~f[4] : ~(p ^ f[4]);
      chk("tx_par_bit", e_par, tx_par_bit);
      rx_par_bit <= ~e_par;
      rx_par_stb <= 1'b1;
      @(posedge mclk);
      rx_par_stb <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("rx_par_err", f[3], rx_par_err);
    end
    apb(1'b1, OFS_LINE_FMT, 8'h40);
    @(posedge mclk);
    chk("tx_line", 0, tx_line);
    apb(1'b1, OFS_LINE_FMT, 8'h00);
    @(posedge mclk);
    chk("tx_line", 1, tx_line);
    close_out;
  end
endmodule // uart_fifo_format_interrupt_tb
`default_nettype wire
